// ---- common/buffered_write_map.vh ----
// constants for the buffered disk write control block
// assumes a single device clock and a synchronous active-low reset
`ifndef BUFFERED_WRITE_MAP_VH
`define BUFFERED_WRITE_MAP_VH
`define ADDR_CTRL      4'h0
`define ADDR_SECT_LEN  4'h1
`define ADDR_RATE      4'h2
`define ADDR_STATUS    4'h3
`define ADDR_RESIDUAL  4'h4
`define ADDR_OCCUPANCY 4'h5
`define CTRL_FULL      0
`define CTRL_XCYL      1
`define CTRL_READ      2
`define CTRL_RST       3'h0
`define SECT_LEN_RST   16'h0200
`define RATE_RST       8'h00
`define ST_OK          8'h00
`define ST_BUSY        8'h81
`define ST_FINISH      8'h90
`define ST_EOC         8'h99
`define ST_PEND        8'h89
`define ST_AFTER       8'h8c
`define ST_OOC         8'h98
`define CLS_DONE       2'h1
`define CLS_AVAIL      2'h2
`define CLS_EXC        2'h3
`define CTL_DATA       2'h0
`define CTL_FINISH     2'h1
`define CTL_RDSTAT     2'h2
`define CTL_OTHER      2'h3
`define INT_LAG        8'h10
`endif

// ---- rtl/sector_buffer.v ----
// byte buffer with occupancy count for the buffered write control
// assumes callers never push when full nor pop when empty
`timescale 1ns/10ps
module sector_buffer #(
  parameter WIDTH = 8,
  parameter AW    = 12
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire             clear,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  input  wire             pop,
  output wire [WIDTH-1:0] pop_data,
  output reg  [15:0]      count
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0]    wptr;
  reg [AW-1:0]    rptr;

  assign pop_data = mem[rptr];

  always @(posedge ref_clk)
  begin
    if (push)
      mem[wptr] <= push_data;
  end

  // occupancy is tracked in bytes
  always @(posedge ref_clk)
  begin
    if (!rst_n || clear)
    begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= 16'h0000;
    end
    else
    begin
      if (push)
        wptr <= wptr + 1'b1;
      if (pop)
        rptr <= rptr + 1'b1;
      if (push && !pop)
        count <= count + 16'h0001;
      else if (pop && !push)
        count <= count - 16'h0001;
    end
  end
endmodule // sector_buffer

// ---- rtl/buffered_write_ctrl.v ----
// buffered write and full sector read control of a disk slave
// assumes the master keeps bus controls one cycle long and that media
// strobes come from the disk sequencer on the same clock
`timescale 1ns/10ps
`include "buffered_write_map.vh"
module buffered_write_ctrl #(
  parameter AW = 12
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [15:0] reg_rdata,
  input  wire        start_write_mode,
  input  wire        ctl_valid,
  input  wire [1:0]  ctl_kind,
  output reg         status_valid,
  output reg  [7:0]  status_code,
  output reg         int_valid,
  output reg  [1:0]  int_class,
  input  wire        host_wr_valid,
  input  wire [7:0]  host_wr_data,
  output wire        host_wr_ready,
  output wire        host_rd_valid,
  output wire [7:0]  host_rd_data,
  input  wire        host_rd_ready,
  output wire [7:0]  iface_rate,
  input  wire        media_sector_mark,
  input  wire        media_byte_req,
  output wire [7:0]  media_wr_data,
  output wire        media_wr_gate,
  input  wire        media_rd_valid,
  input  wire [7:0]  media_rd_data,
  output wire        media_rd_ready,
  input  wire        media_eoc,
  input  wire        last_cyl,
  input  wire        field_end,
  input  wire        logical_reset,
  input  wire        alt_allegiance
);
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_WBM   = 3'h1;
  localparam [2:0] S_DRAIN = 3'h2;
  localparam [2:0] S_EXC   = 3'h3;
  localparam [2:0] S_POST  = 3'h4;
  localparam [15:0] DEPTH  = 16'h0001 << AW;

  ////////////////////////////////////////////////////////////////////
  reg  [2:0]  ctrl;
  reg  [15:0] sect_len;
  reg  [7:0]  rate;
  reg  [2:0]  state;
  reg         in_sector;
  reg  [15:0] byte_cnt;
  reg  [15:0] credit;
  reg  [15:0] residual;
  reg  [7:0]  lag;
  reg         ooc;
  reg         eoc_flag;
  reg         late_flag;
  reg         lr_pend;
  reg         avail_pend;
  reg         avail_q;
  wire [15:0] occ;
  wire [7:0]  pop_data;
  wire        full_mode;
  wire        read_mode;
  wire        writing;
  wire        space_ok;
  wire        have_sector;
  wire        can_start;
  wire        eoc_hit;
  wire        media_pop;
  wire        host_pop;
  wire        fill_push;
  wire        wr_push;
  wire        late_hit;
  wire        done_hit;
  wire        lr_act;
  wire        clear_buf;

  function at_least;
    input [15:0] have;
    input [15:0] need;
    begin
      at_least = (have >= need);
    end
  endfunction

  assign full_mode   = ctrl[`CTRL_FULL];
  assign read_mode   = ctrl[`CTRL_READ];
  assign writing     = (state == S_WBM) || (state == S_DRAIN);
  assign space_ok    = at_least(DEPTH - occ, sect_len);
  assign have_sector = at_least(occ, sect_len);
  // full sector write waits for a whole sector
  assign can_start   = full_mode ? have_sector : (occ != 16'h0000);
  assign eoc_hit     = media_eoc && (!ctrl[`CTRL_XCYL] || last_cyl);
  assign late_hit    = writing && in_sector && media_byte_req && (occ == 16'h0000);
  assign media_pop   = writing && in_sector && media_byte_req && (occ != 16'h0000);
  assign done_hit    = (state == S_DRAIN) && !in_sector && (occ == 16'h0000);
  assign lr_act      = lr_pend && (field_end || !in_sector);
  assign clear_buf   = lr_act || (state == S_IDLE && start_write_mode && !read_mode);

  assign host_wr_ready = (state == S_WBM) && !at_least(occ, DEPTH);
  assign wr_push       = host_wr_valid && host_wr_ready;
  assign media_rd_ready = read_mode && (state == S_IDLE) && !at_least(occ, DEPTH);
  assign fill_push     = media_rd_valid && media_rd_ready;
  // sector credit gates read data to whole sectors
  assign host_rd_valid = read_mode && (credit != 16'h0000) && (occ != 16'h0000);
  assign host_pop      = host_rd_valid && host_rd_ready;
  assign host_rd_data  = pop_data;
  assign media_wr_data = pop_data;
  assign media_wr_gate = writing && in_sector;
  // interface rate stays at the agreed value in every mode
  assign iface_rate    = rate;

  sector_buffer #(
    .WIDTH (8),
    .AW    (AW)
  ) u_buf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clear     (clear_buf),
    .push      (wr_push || fill_push),
    .push_data (wr_push ? host_wr_data : media_rd_data),
    .pop       (media_pop || host_pop),
    .pop_data  (pop_data),
    .count     (occ)
  );

  ////////////////////////////////////////////////////////////////////
  // register port
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctrl      <= `CTRL_RST;
      sect_len  <= `SECT_LEN_RST;
      rate      <= `RATE_RST;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      if (reg_write)
      begin
        if (reg_addr == `ADDR_CTRL)
          ctrl <= reg_wdata[2:0];
        else if (reg_addr == `ADDR_SECT_LEN)
          sect_len <= reg_wdata;
        else if (reg_addr == `ADDR_RATE)
          rate <= reg_wdata[7:0];
      end
      if (reg_read)
      begin
        if (reg_addr == `ADDR_CTRL)
          reg_rdata <= {13'h0000, ctrl};
        else if (reg_addr == `ADDR_SECT_LEN)
          reg_rdata <= sect_len;
        else if (reg_addr == `ADDR_RATE)
          reg_rdata <= {8'h00, rate};
        else if (reg_addr == `ADDR_STATUS)
          reg_rdata <= {8'h00, in_sector, lr_pend, ooc, eoc_flag, late_flag, state};
        else if (reg_addr == `ADDR_RESIDUAL)
          reg_rdata <= residual;
        else if (reg_addr == `ADDR_OCCUPANCY)
          reg_rdata <= occ;
        else
          reg_rdata <= 16'h0000;
      end
      else
        reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // media sector engine
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      in_sector <= 1'b0;
      byte_cnt  <= 16'h0000;
    end
    else if (!writing || late_hit || eoc_hit || lr_act)
    begin
      in_sector <= 1'b0;
      byte_cnt  <= 16'h0000;
    end
    else if (!in_sector)
    begin
      // without data the sector mark passes and a revolution slips
      if (media_sector_mark && can_start)
        in_sector <= 1'b1;
      byte_cnt <= 16'h0000;
    end
    else if (media_pop)
    begin
      if (byte_cnt == sect_len - 16'h0001)
      begin
        in_sector <= 1'b0;
        byte_cnt  <= 16'h0000;
      end
      else
        byte_cnt <= byte_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read sector credit
  always @(posedge ref_clk)
  begin
    if (!rst_n || !read_mode)
      credit <= 16'h0000;
    else if (ctl_valid && ctl_kind == `CTL_DATA && state == S_IDLE
             && have_sector && credit == 16'h0000)
      credit <= sect_len;
    else if (host_pop)
      credit <= credit - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////
  // mode control, status and interrupts
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state        <= S_IDLE;
      status_valid <= 1'b0;
      status_code  <= `ST_OK;
      int_valid    <= 1'b0;
      int_class    <= `CLS_DONE;
      residual     <= 16'h0000;
      lag          <= 8'h00;
      ooc          <= 1'b0;
      eoc_flag     <= 1'b0;
      late_flag    <= 1'b0;
      lr_pend      <= 1'b0;
      avail_pend   <= 1'b0;
      avail_q      <= 1'b0;
    end
    else
    begin
      status_valid <= 1'b0;
      int_valid    <= 1'b0;
      avail_q      <= space_ok;
      if (logical_reset && !alt_allegiance && writing)
        lr_pend <= 1'b1;
      if (ctl_valid)
      begin
        status_valid <= 1'b1;
        status_code  <= `ST_OK;
      end
      if (state == S_WBM && space_ok && !avail_q)
        avail_pend <= 1'b1;
      case (state)
        S_IDLE:
        begin
          if (ctl_valid && ctl_kind == `CTL_DATA && read_mode && !have_sector)
            status_code <= `ST_BUSY;
          if (start_write_mode && !read_mode)
          begin
            state      <= S_WBM;
            ooc        <= 1'b0;
            eoc_flag   <= 1'b0;
            late_flag  <= 1'b0;
            lr_pend    <= 1'b0;
            avail_pend <= 1'b1;
          end
        end
        S_WBM:
        begin
          if (ctl_valid)
          begin
            if (ctl_kind == `CTL_DATA)
            begin
              if (!space_ok)
                status_code <= `ST_BUSY;
            end
            else if (ctl_kind == `CTL_FINISH)
            begin
              status_code <= `ST_FINISH;
              state       <= S_DRAIN;
            end
            else
            begin
              status_code <= `ST_OOC;
              ooc         <= 1'b1;
              state       <= S_DRAIN;
            end
          end
        end
        S_DRAIN:
        begin
          if (ctl_valid)
          begin
            if (ooc)
              status_code <= `ST_PEND;
            else
            begin
              status_code <= `ST_OOC;
              ooc         <= 1'b1;
            end
          end
          if (done_hit)
          begin
            int_valid <= 1'b1;
            // an out-of-context exit reports completion as class 3
            int_class <= ooc ? `CLS_EXC : `CLS_DONE;
            state     <= ooc ? S_POST : S_IDLE;
          end
        end
        S_EXC:
        begin
          if (ctl_valid)
            status_code <= `ST_PEND;
          if (lag == 8'h00)
          begin
            int_valid <= 1'b1;
            int_class <= `CLS_EXC;
            state     <= S_POST;
          end
          else
            lag <= lag - 8'h01;
        end
        S_POST:
        begin
          if (ctl_valid)
          begin
            // reading status closes the exit
            if (ctl_kind == `CTL_RDSTAT)
              state <= S_IDLE;
            else
              status_code <= `ST_AFTER;
          end
        end
        default:
          state <= S_IDLE;
      endcase
      if (state == S_WBM && avail_pend && !ctl_valid)
      begin
        int_valid  <= 1'b1;
        int_class  <= `CLS_AVAIL;
        avail_pend <= space_ok && !avail_q; // a new space event wins over the clear
      end
      if (writing && late_hit)
      begin
        late_flag <= 1'b1;
        lag       <= `INT_LAG;
        state     <= S_EXC;
      end
      else if (writing && eoc_hit && occ != 16'h0000)
      begin
        eoc_flag     <= 1'b1;
        residual     <= occ;
        status_valid <= 1'b1;
        status_code  <= `ST_EOC;
        lag          <= `INT_LAG;
        state        <= S_EXC;
      end
      if (lr_act)
      begin
        lr_pend    <= 1'b0;
        avail_pend <= 1'b0;
        state      <= S_IDLE;
      end
    end
  end
endmodule // buffered_write_ctrl

// ---- testbench/buffered_write_ctrl_assertions.sv ----
// checker for the buffered write control, bound to its top module
// assumes one clock and the status codes of the shared map header
`timescale 1ns/10ps
`include "buffered_write_map.vh"
module buffered_write_checker (
  input wire       ref_clk,
  input wire       rst_n,
  input wire       reg_write,
  input wire [7:0] iface_rate,
  input wire       start_write_mode,
  input wire       ctl_valid,
  input wire [1:0] ctl_kind,
  input wire       status_valid,
  input wire [7:0] status_code,
  input wire       int_valid,
  input wire [1:0] int_class,
  input wire       host_wr_ready,
  input wire       media_eoc,
  input wire       last_cyl,
  input wire       media_wr_gate
);
  reg pend;
  reg post;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // pend: exit reported, interrupt not yet raised; post: after that interrupt
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pend <= 1'b0;
      post <= 1'b0;
    end
    else
    begin
      if (status_valid && (status_code == `ST_EOC || status_code == `ST_OOC))
        pend <= 1'b1;
      else if (int_valid)
        pend <= 1'b0;
      if (int_valid && int_class == `CLS_EXC && pend)
        post <= 1'b1;
      else if (status_valid && status_code == `ST_OK)
        post <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ctl_answered: assert property (ctl_valid |=> status_valid)
    else $error("bus control got no status");
  a_finish_code: assert property (ctl_valid && ctl_kind == `CTL_FINISH && host_wr_ready
    && !media_eoc |=> status_code == `ST_FINISH) else $error("finish status wrong");
  a_ooc_code: assert property (ctl_valid && ctl_kind == `CTL_OTHER && host_wr_ready
    && !media_eoc |=> status_code == `ST_OOC) else $error("out of context status wrong");
  a_rate_steady: assert property ($stable(iface_rate) || $past(reg_write))
    else $error("interface rate changed");
  a_eoc_stop: assert property (media_eoc && last_cyl && media_wr_gate
    |=> status_valid && status_code == `ST_EOC && !media_wr_gate) else $error("eoc exit wrong");
  a_eoc_class3: assert property (status_valid && status_code == `ST_EOC
    |-> ##[14:18] int_valid && int_class == `CLS_EXC) else $error("eoc interrupt missing");
  a_pend_code: assert property (pend && ctl_valid && !int_valid
    |=> status_code == `ST_PEND) else $error("pending status wrong");
  a_after_code: assert property (post && ctl_valid && ctl_kind != `CTL_RDSTAT
    |=> status_code == `ST_AFTER) else $error("post interrupt status wrong");
  a_entry_avail: assert property (start_write_mode ##1 (host_wr_ready && !ctl_valid)
    |=> int_valid && int_class == `CLS_AVAIL) else $error("no buffer available interrupt");
  cover property (status_valid && status_code == `ST_OOC);
  cover property (status_valid && status_code == `ST_EOC);
  cover property (int_valid && int_class == `CLS_DONE);
endmodule // buffered_write_checker

bind buffered_write_ctrl buffered_write_checker buffered_write_checker_inst (.ref_clk, .rst_n,
  .reg_write, .iface_rate, .start_write_mode, .ctl_valid, .ctl_kind, .status_valid, .status_code,
  .int_valid, .int_class, .host_wr_ready, .media_eoc, .last_cyl, .media_wr_gate);

// ---- testbench/disk_media_model.sv ----
// disk sequencer model: sector marks and byte requests, read bytes
// assumes the control block shares its clock
`timescale 1ns/10ps
module disk_media_model (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       run_wr,
  input  wire       run_rd,
  input  wire       media_wr_gate,
  input  wire       media_rd_ready,
  output reg        media_sector_mark,
  output reg        media_byte_req,
  output wire       media_rd_valid,
  output wire [7:0] media_rd_data
);
  reg [5:0] tick;
  reg [5:0] rcnt;
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tick <= 6'h00;
      rcnt <= 6'h00;
      media_sector_mark <= 1'b0;
      media_byte_req <= 1'b0;
    end
    else
    begin
      tick <= run_wr ? tick + 6'h01 : 6'h00;
      media_sector_mark <= run_wr && tick == 6'h00;
      media_byte_req <= media_wr_gate && tick[0];
      if (!run_rd)
        rcnt <= 6'h00;
      else if (media_rd_valid && media_rd_ready)
        rcnt <= rcnt + 6'h01;
    end
  end
  // idle data shows the inverse so a stale byte never looks valid
  assign media_rd_valid = run_rd && rcnt < 6'h20;
  assign media_rd_data = media_rd_valid ? {2'h0, rcnt} : ~{2'h0, rcnt};
endmodule // disk_media_model

// ---- testbench/buffered_write_ctrl_test.sv ----
// self-checking bench for the buffered write control
// assumes the map header and a 32-byte buffer with 16-byte sectors
`timescale 1ns/10ps
`include "buffered_write_map.vh"
module buffered_write_ctrl_test;
  reg          ref_clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, start_write_mode = 0;
  reg          ctl_valid = 0, host_wr_valid = 0, host_rd_ready = 0, media_eoc = 0;
  reg          logical_reset = 0, run_wr = 0, run_rd = 0, rd_d = 0, last_cyl = 1;
  reg          alt_allegiance = 0;
  reg  [3:0]   reg_addr = 0;
  reg  [15:0]  reg_wdata = 0;
  reg  [1:0]   ctl_kind = 0;
  reg  [7:0]   host_wr_data = 0;
  wire [15:0]  reg_rdata;
  wire         status_valid, int_valid, host_wr_ready, host_rd_valid, media_sector_mark;
  wire         media_byte_req, media_wr_gate, media_rd_valid, media_rd_ready;
  wire [7:0]   status_code, host_rd_data, iface_rate, media_wr_data, media_rd_data;
  wire [1:0]   int_class;
  integer      err_count = 0, checks_done = 0, cyc = 0, n;
  logic [15:0] sq[$], iq[$], wq[$], rq[$], gq[$];
  buffered_write_ctrl #(.AW(5)) buffered_write_ctrl_inst (.ref_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .start_write_mode, .ctl_valid, .ctl_kind,
    .status_valid, .status_code, .int_valid, .int_class, .host_wr_valid, .host_wr_data,
    .host_wr_ready, .host_rd_valid, .host_rd_data, .host_rd_ready, .iface_rate,
    .media_sector_mark, .media_byte_req, .media_wr_data, .media_wr_gate, .media_rd_valid,
    .media_rd_data, .media_rd_ready, .media_eoc, .last_cyl, .field_end(1'b0),
    .logical_reset, .alt_allegiance);
  disk_media_model disk_media_model_inst (.ref_clk, .rst_n, .run_wr, .run_rd, .media_wr_gate,
    .media_rd_ready, .media_sector_mark, .media_byte_req, .media_rd_valid, .media_rd_data);
  initial
    forever #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task rw(input [3:0] a, input [15:0] d, input wr);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= wr;
    reg_read <= !wr;
    if (!wr) rq.push_back(d);
    @(posedge ref_clk);
    reg_write <= 0;
    reg_read <= 0;
  endtask
  task ctl(input [1:0] k, input [7:0] e);
    @(posedge ref_clk);
    ctl_valid <= 1;
    ctl_kind <= k;
    sq.push_back(e);
    @(posedge ref_clk);
    ctl_valid <= 0;
  endtask
  task wait_int(input integer lim);
    repeat (lim) if (iq.size()) @(posedge ref_clk);
    chk(16'h0, 16'(iq.size()));
  endtask
  task start;
    iq.push_back(`CLS_AVAIL);
    @(posedge ref_clk);
    start_write_mode <= 1;
    @(posedge ref_clk);
    start_write_mode <= 0;
    wait_int(40);
  endtask
  task push(input integer cnt);
    logic [7:0] d;
    repeat (cnt)
    begin
      d = $urandom;
      host_wr_valid <= 1;
      host_wr_data <= d;
      @(negedge ref_clk);
      while (!host_wr_ready) @(negedge ref_clk);
      @(posedge ref_clk);
      wq.push_back(d);
    end
    host_wr_valid <= 0;
  endtask
  task after_exc;
    ctl(`CTL_DATA, `ST_AFTER);
    ctl(`CTL_RDSTAT, `ST_OK);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk)
  begin
    if (status_valid) chk(sq.size() ? sq.pop_front() : 16'hxxxx, {8'h00, status_code});
    if (int_valid) chk(iq.size() ? iq.pop_front() : 16'hxxxx, {14'h0, int_class});
    if (media_byte_req && media_wr_gate && wq.size()) chk(wq.pop_front(), {8'h0, media_wr_data});
    if (host_rd_valid && host_rd_ready) chk(gq.pop_front(), {8'h00, host_rd_data});
    if (rd_d) chk(rq.pop_front(), reg_rdata);
  end
  always @(posedge ref_clk)
  begin
    rd_d <= reg_read;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test;
    end
  end
  initial
  begin
    void'($urandom(32'h2a428137));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1;
    rw(`ADDR_CTRL, 16'h0000, 0);
    rw(`ADDR_SECT_LEN, `SECT_LEN_RST, 0);
    rw(4'hf, 16'h0000, 0);
    rw(`ADDR_SECT_LEN, 16'h0010, 1);
    rw(`ADDR_RATE, 16'h0033, 1);
    rw(`ADDR_CTRL, 16'h0004, 1);
    ctl(`CTL_DATA, `ST_BUSY);
    for (n = 0; n < 32; n++) gq.push_back(n);
    run_rd <= 1;
    repeat (60) @(posedge ref_clk);
    rw(`ADDR_OCCUPANCY, 16'h0020, 0);
    repeat (2)
    begin
      ctl(`CTL_DATA, `ST_OK);
      host_rd_ready <= 1;
      n = 0;
      repeat (24) @(negedge ref_clk) n += host_rd_valid;
      @(posedge ref_clk);
      host_rd_ready <= 0;
      chk(16'h0010, 16'(n));
    end
    chk(16'h0033, {8'h00, iface_rate});
    run_rd <= 0;
    rw(`ADDR_CTRL, 16'h0001, 1);
    start;
    ctl(`CTL_DATA, `ST_OK);
    push(32);
    ctl(`CTL_DATA, `ST_BUSY);
    iq.push_back(`CLS_AVAIL);
    run_wr <= 1;
    wait_int(200);
    ctl(`CTL_FINISH, `ST_FINISH);
    iq.push_back(`CLS_DONE);
    wait_int(300);
    run_wr <= 0;
    start;
    push(8);
    run_wr <= 1;
    repeat (70) @(posedge ref_clk);
    rw(`ADDR_OCCUPANCY, 16'h0008, 0);
    push(8);
    ctl(`CTL_FINISH, `ST_FINISH);
    iq.push_back(`CLS_DONE);
    wait_int(300);
    run_wr <= 0;
    rw(`ADDR_CTRL, 16'h0000, 1);
    start;
    push(16);
    ctl(`CTL_OTHER, `ST_OOC);
    ctl(`CTL_DATA, `ST_PEND);
    iq.push_back(`CLS_EXC);
    run_wr <= 1;
    wait_int(300);
    rw(`ADDR_STATUS, 16'h0024, 0);
    run_wr <= 0;
    after_exc;
    start;
    push(4);
    alt_allegiance <= 1;
    logical_reset <= 1;
    @(posedge ref_clk);
    alt_allegiance <= 0;
    logical_reset <= 0;
    rw(`ADDR_OCCUPANCY, 16'h0004, 0);
    logical_reset <= 1;
    @(posedge ref_clk);
    logical_reset <= 0;
    repeat (4) @(posedge ref_clk);
    rw(`ADDR_OCCUPANCY, 16'h0000, 0);
    rw(`ADDR_STATUS, 16'h0000, 0);
    wq.delete();
    start;
    push(4);
    iq.push_back(`CLS_EXC);
    run_wr <= 1;
    wait_int(300);
    run_wr <= 0;
    rw(`ADDR_STATUS, 16'h000c, 0);
    after_exc;
    rw(`ADDR_CTRL, 16'h0002, 1);
    last_cyl <= 0;
    start;
    push(16);
    run_wr <= 1;
    n = 0;
    while (!media_wr_gate && n < 200) @(negedge ref_clk) n++;
    @(posedge ref_clk);
    media_eoc <= 1;
    sq.push_back(`ST_EOC);
    iq.push_back(`CLS_EXC);
    @(posedge ref_clk);
    last_cyl <= 1;
    @(posedge ref_clk);
    media_eoc <= 0;
    ctl(`CTL_DATA, `ST_PEND);
    wait_int(100);
    rw(`ADDR_RESIDUAL, 16'h0010, 0);
    rw(`ADDR_STATUS, 16'h0014, 0);
    run_wr <= 0;
    after_exc;
    wq.delete();
    finish_test;
  end
endmodule // buffered_write_ctrl_test
